/* File: design/tcf_time_control.sv */
// Time-of-day counter, display multiplexer, control pulses and fault decoder
`timescale 1ns/1ps
`default_nettype none
`include "tcf_defines.svh"

// Operation
// - Seconds and minutes units wrap after ten
// - Seconds and minutes tens count modulo six
// - Hours count modulo twenty-four from minute carry
// - One decade per scan step on four lines
// - Seconds, minutes, hours load independently
// - Function selector is four-state one-hot ring
// - Function button pulse advances selector one step
// - Lamps show the selected function
// - Range counter steps on each start pulse
// - Range selector marks blanked digit being set
// - Digit being set flashes at five hertz
// - Divider reset pulses of 0.05 and 0.5 ms
// - Query pulse from external or auxiliary scale
// - Inverted deviation pulse zeroes main divider in deviation function
// - Zero pulse also clears and presets mixer divider
// - Plus or minus lamp follows comparator flags
// - Missing lock flashes red, enables fault decoder
// - Enabled decoder shows defective assembly number
// - Fault codes one to nine, seven unused
// - At most one faulty assembly assumed
module tcf_time_control
    import tcf_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = `TCF_SEC_CYCLES,
    parameter int unsigned BLINK_HALF_CYCLES = `TCF_BLINK_HALF_CYCLES,
    parameter int unsigned CORR_LONG_CYCLES = `TCF_CORR_LONG_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Front panel and display scan
    input wire logic funcBtnPulse,
    input wire logic startBtnPulse,
    input wire logic [2:0] scanSel,
    output logic [3:0] digitCode,
    output logic digitBlank,
    output logic [3:0] rangeSel,
    output logic lampTime,
    output logic lampInterval,
    output logic lampDeviation,
    // Time scales and divider control
    input wire logic extScale,
    input wire logic auxScale,
    input wire logic devPulseN,
    output logic queryOut,
    output logic divRst10,
    output logic divRst1,
    output logic mainDivZero,
    output logic mixClear,
    output logic mixPreset9,
    // Monitoring and fault decoding
    input wire logic cmpPlus,
    input wire logic cmpMinus,
    input wire logic harmLock,
    input wire logic [8:0] faultFlags,
    output logic lampPlus,
    output logic lampMinus,
    output logic lampRed,
    output logic lampGreen,
    output logic faultDecEn,
    output logic [3:0] faultCode
);

    localparam int unsigned CORR_SHORT_CYCLES = `TCF_CORR_SHORT_CYCLES;

    tcf_state_t st;
    tcf_state_t nxt;
    logic secTick;
    logic setWrite;
    logic [31:0] readMux;
    logic [3:0] scanDigit;
    logic [3:0] faultEnc;

    // ==========================================================
    // Helpers

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = data[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Lowest flagged assembly wins; only one is expected at a time
    always_comb begin
        faultEnc = 4'h0;
        for (int i = 8; i >= 0; i--) begin
            if (faultFlags[i] && i != 6) begin
                faultEnc = 4'(i + 1);
            end
        end
    end

    // ==========================================================
    // Read mux and display source

    always_comb begin
        readMux = 32'h0;
        unique case (araddr)
            `TCF_OFS_CTRL: readMux = {30'h0, st.querySel, st.setMode};
            `TCF_OFS_TIME: readMux = {8'h0, st.hrT, st.hrU, st.minT, st.minU, st.secT, st.secU};
            `TCF_OFS_STATUS: readMux = {16'h0, st.blinkPhase, st.lampMinus, st.lampPlus,
                                        st.faultDecEn, st.faultCode, st.rangeSel, st.func};
            default: readMux = 32'h0;
        endcase
    end

    always_comb begin
        unique case (scanSel)
            3'h0: scanDigit = st.secU;
            3'h1: scanDigit = st.secT;
            3'h2: scanDigit = st.minU;
            3'h3: scanDigit = st.minT;
            3'h4: scanDigit = st.hrU;
            3'h5: scanDigit = st.hrT;
            default: scanDigit = 4'h0;
        endcase
    end

    assign secTick = (st.tickCnt == 26'(SEC_CYCLES - 1));
    assign setWrite = st.awHeld && st.wHeld && !st.bvalid && (st.awAddr == `TCF_OFS_SETTIME);

    // ==========================================================
    // Next state

    always_comb begin
        logic doWrite;
        logic [31:0] wv;
        logic carry;
        nxt = st;
        doWrite = st.awHeld && st.wHeld && !st.bvalid;
        wv = 32'h0;
        carry = 1'b0;

        // Bus: address and data are taken independently, answered once both are in
        if (awvalid && st.awready) begin
            nxt.awHeld = 1'b1;
            nxt.awAddr = awaddr;
        end
        if (wvalid && st.wready) begin
            nxt.wHeld = 1'b1;
            nxt.wData = wdata;
            nxt.wStrb = wstrb;
        end
        if (st.bvalid && bready) begin
            nxt.bvalid = 1'b0;
        end
        if (arvalid && st.arready) begin
            nxt.rvalid = 1'b1;
            nxt.rdata = readMux;
            nxt.rresp = (araddr == `TCF_OFS_CTRL || araddr == `TCF_OFS_TIME ||
                         araddr == `TCF_OFS_STATUS || araddr == `TCF_OFS_CMD ||
                         araddr == `TCF_OFS_SETTIME) ? `TCF_RESP_OKAY : `TCF_RESP_SLVERR;
        end else if (st.rvalid && rready) begin
            nxt.rvalid = 1'b0;
        end

        // Seconds reference and blink phase
        nxt.tickCnt = secTick ? 26'h0 : st.tickCnt + 26'h1;
        if (st.blinkCnt == 23'(BLINK_HALF_CYCLES - 1)) begin
            nxt.blinkCnt = 23'h0;
            nxt.blinkPhase = !st.blinkPhase;
        end else begin
            nxt.blinkCnt = st.blinkCnt + 23'h1;
        end

        // Time decades; carries ripple within the same cycle
        if (secTick) begin
            carry = 1'b1;
            if (st.secU == `TCF_UNITS_MAX) begin
                nxt.secU = 4'h0;
            end else begin
                nxt.secU = st.secU + 4'h1;
                carry = 1'b0;
            end
            if (carry) begin
                if (st.secT == `TCF_TENS_MAX) begin
                    nxt.secT = 4'h0;
                end else begin
                    nxt.secT = st.secT + 4'h1;
                    carry = 1'b0;
                end
            end
            if (carry) begin
                if (st.minU == `TCF_UNITS_MAX) begin
                    nxt.minU = 4'h0;
                end else begin
                    nxt.minU = st.minU + 4'h1;
                    carry = 1'b0;
                end
            end
            if (carry) begin
                if (st.minT == `TCF_TENS_MAX) begin
                    nxt.minT = 4'h0;
                end else begin
                    nxt.minT = st.minT + 4'h1;
                    carry = 1'b0;
                end
            end
            if (carry) begin
                if (st.hrT == `TCF_HOUR_TENS_LAST && st.hrU == `TCF_HOUR_UNITS_LAST) begin
                    nxt.hrU = 4'h0;
                    nxt.hrT = 4'h0;
                end else if (st.hrU == `TCF_UNITS_MAX) begin
                    nxt.hrU = 4'h0;
                    nxt.hrT = st.hrT + 4'h1;
                end else begin
                    nxt.hrU = st.hrU + 4'h1;
                end
            end
        end

        // Register writes; a load overrides a tick in the same cycle
        if (doWrite) begin
            nxt.awHeld = 1'b0;
            nxt.wHeld = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = `TCF_RESP_OKAY;
            unique case (st.awAddr)
                `TCF_OFS_CTRL: begin
                    wv = mergeBytes({30'h0, st.querySel, st.setMode}, st.wData, st.wStrb);
                    nxt.setMode = wv[`TCF_CTRL_SETMODE];
                    nxt.querySel = wv[`TCF_CTRL_QSRC];
                end
                `TCF_OFS_CMD: begin
                    wv = mergeBytes(32'h0, st.wData, st.wStrb);
                    if (wv[`TCF_CMD_CORR]) begin
                        nxt.corrShortCnt = 12'(CORR_SHORT_CYCLES);
                        nxt.corrLongCnt = 15'(CORR_LONG_CYCLES);
                    end
                end
                `TCF_OFS_SETTIME: begin
                    wv = mergeBytes(32'h0, st.wData, st.wStrb);
                    if (wv[`TCF_SET_LDSEC]) begin
                        nxt.secU = wv[3:0];
                        nxt.secT = wv[7:4];
                        nxt.tickCnt = 26'h0;
                    end
                    if (wv[`TCF_SET_LDMIN]) begin
                        nxt.minU = wv[11:8];
                        nxt.minT = wv[15:12];
                    end
                    if (wv[`TCF_SET_LDHR]) begin
                        nxt.hrU = wv[19:16];
                        nxt.hrT = wv[23:20];
                    end
                end
                `TCF_OFS_TIME, `TCF_OFS_STATUS: begin
                    nxt.bresp = `TCF_RESP_OKAY;
                end
                default: nxt.bresp = `TCF_RESP_SLVERR;
            endcase
        end
        nxt.awready = !nxt.awHeld && !nxt.bvalid;
        nxt.wready = !nxt.wHeld && !nxt.bvalid;
        nxt.arready = !nxt.rvalid;

        // Correction pulses; the long one covers the slower divider chain
        nxt.divRst10 = (st.corrShortCnt != 12'h0);
        nxt.divRst1 = (st.corrLongCnt != 15'h0);
        if (st.corrShortCnt != 12'h0 && !(doWrite && st.awAddr == `TCF_OFS_CMD)) begin
            nxt.corrShortCnt = st.corrShortCnt - 12'h1;
        end
        if (st.corrLongCnt != 15'h0 && !(doWrite && st.awAddr == `TCF_OFS_CMD)) begin
            nxt.corrLongCnt = st.corrLongCnt - 15'h1;
        end

        // Function and range selectors
        if (funcBtnPulse) begin
            nxt.func = tcf_func_t'({st.func[2:0], st.func[3]});
        end
        if (startBtnPulse) begin
            nxt.range = st.range + 2'h1;
        end
        nxt.rangeSel = 4'h1 << nxt.range;
        nxt.lampTime = (nxt.func == FN_TIME);
        nxt.lampInterval = (nxt.func == FN_INTERVAL);
        nxt.lampDeviation = (nxt.func == FN_DEVIATION);

        // Query source switch
        nxt.queryOut = st.querySel ? extScale : auxScale;

        // Deviation pulse is active low; in the deviation function its leading edge yields one zero-setting pulse
        nxt.devPrev = devPulseN;
        nxt.mainDivZero = st.devPrev && !devPulseN && (st.func == FN_DEVIATION);
        nxt.mixClear = nxt.mainDivZero;
        nxt.mixPreset9 = nxt.mainDivZero;

        // Monitoring lamps and fault decoder
        nxt.lampPlus = cmpPlus;
        nxt.lampMinus = cmpMinus;
        nxt.faultDecEn = !harmLock;
        nxt.lampRed = !harmLock && st.blinkPhase;
        nxt.lampGreen = harmLock;
        nxt.faultCode = harmLock ? 4'h0 : faultEnc;

        // Display: fault number takes the first position while the decoder is enabled
        if (st.faultDecEn) begin
            nxt.digitCode = (scanSel == 3'h0) ? st.faultCode : 4'h0;
            nxt.digitBlank = (scanSel != 3'h0);
        end else begin
            nxt.digitCode = scanDigit;
            nxt.digitBlank = (st.func != FN_TIME) || (scanSel > 3'h5) ||
                             (st.setMode && st.range != `TCF_RANGE_IDLE &&
                              st.range == 2'(scanSel >> 1) && st.blinkPhase);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st <= '0;
            st.func <= FN_TIME;
            st.rangeSel <= 4'h1;
            st.lampTime <= 1'b1;
            st.devPrev <= 1'b1;
            st.digitBlank <= 1'b1;
        end else begin
            st <= nxt;
        end
    end

    // ==========================================================
    // Outputs

    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign digitCode = st.digitCode;
    assign digitBlank = st.digitBlank;
    assign rangeSel = st.rangeSel;
    assign lampTime = st.lampTime;
    assign lampInterval = st.lampInterval;
    assign lampDeviation = st.lampDeviation;
    assign queryOut = st.queryOut;
    assign divRst10 = st.divRst10;
    assign divRst1 = st.divRst1;
    assign mainDivZero = st.mainDivZero;
    assign mixClear = st.mixClear;
    assign mixPreset9 = st.mixPreset9;
    assign lampPlus = st.lampPlus;
    assign lampMinus = st.lampMinus;
    assign lampRed = st.lampRed;
    assign lampGreen = st.lampGreen;
    assign faultDecEn = st.faultDecEn;
    assign faultCode = st.faultCode;

    // ==========================================================
    // Assertions

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_sec_units_wrap: assert property (
        secTick && !setWrite && st.secU == 4'h9 |=> st.secU == 4'h0)
        else $error("seconds units did not wrap");
    a_sec_tens_carry: assert property (
        secTick && !setWrite && st.secU == 4'h9 && st.secT == 4'h5 |=> st.secT == 4'h0)
        else $error("seconds tens did not wrap at six");
    a_day_rollover: assert property (
        secTick && !setWrite && {st.hrT, st.hrU, st.minT, st.minU, st.secT, st.secU} == 24'h235959
        |=> {st.hrT, st.hrU, st.minT, st.minU, st.secT, st.secU} == 24'h000000)
        else $error("day rollover incomplete");
    a_scan_digit: assert property (
        !st.faultDecEn && scanSel == 3'h2 |=> digitCode == $past(st.minU))
        else $error("scan decade wrong");
    a_func_step: assert property (
        funcBtnPulse && st.func == FN_OFF |=> st.func == FN_TIME ##0 lampTime)
        else $error("function selector did not wrap");
    a_func_onehot: assert property (
        $onehot(st.func))
        else $error("function selector not one-hot");
    a_range_step: assert property (
        startBtnPulse |=> st.range == $past(st.range) + 2'h1 ##1 rangeSel == (4'h1 << $past(st.range)))
        else $error("range selector did not step");
    a_corr_short: assert property (
        $rose(divRst10) |-> divRst10 [*8])
        else $error("short correction pulse too brief");
    a_corr_ends: assert property (
        st.corrShortCnt == 12'h1 && !setWrite |=> ##1 !divRst10 || $past(st.corrShortCnt) == 12'h0)
        else $error("short correction pulse overran");
    a_query_src: assert property (
        st.querySel && extScale |=> queryOut)
        else $error("query not from external scale");
    a_zero_pulse: assert property (
        mainDivZero |-> mixClear && mixPreset9 ##1 !mainDivZero)
        else $error("zero-setting pulse malformed");
    a_fault_enable: assert property (
        !harmLock |=> faultDecEn && !lampGreen)
        else $error("fault decoder not enabled on lock loss");
    a_fault_code: assert property (
        !harmLock && faultFlags == 9'h002 |=> faultCode == 4'h2)
        else $error("fault code wrong");
    a_write_resp: assert property (
        st.awHeld && st.wHeld && !st.bvalid |=> bvalid)
        else $error("write not answered");

    c_day_rollover: cover property (
        secTick && {st.hrT, st.hrU, st.minT, st.minU, st.secT, st.secU} == 24'h235959);
    c_blink_set: cover property (st.setMode && digitBlank && st.func == FN_TIME);
    c_fault_shown: cover property (faultDecEn && faultCode != 4'h0);
    c_deviation_zero: cover property (mainDivZero);

endmodule // tcf_time_control
`default_nettype wire

/* File: inc/tcf_defines.svh */
// Offsets, field positions, decade limits, answers and timing counts of the time counter block
`ifndef TCF_DEFINES_SVH
`define TCF_DEFINES_SVH

// ==========================================================
// Clock and timing
`define TCF_CLK_HZ 50000000
`define TCF_CLK_PERIOD_NS 20
`define TCF_BLINK_HZ 5
`define TCF_CORR_SHORT_NS 50000
`define TCF_CORR_LONG_NS 500000
`define TCF_SEC_CYCLES (`TCF_CLK_HZ)
`define TCF_BLINK_HALF_CYCLES (`TCF_CLK_HZ / (2 * `TCF_BLINK_HZ))
`define TCF_CORR_SHORT_CYCLES (`TCF_CORR_SHORT_NS / `TCF_CLK_PERIOD_NS)
`define TCF_CORR_LONG_CYCLES (`TCF_CORR_LONG_NS / `TCF_CLK_PERIOD_NS)

// ==========================================================
// Register byte offsets
`define TCF_OFS_CTRL 8'h00
`define TCF_OFS_CMD 8'h04
`define TCF_OFS_SETTIME 8'h08
`define TCF_OFS_TIME 8'h0c
`define TCF_OFS_STATUS 8'h10

// ==========================================================
// Field positions
`define TCF_CTRL_SETMODE 0
`define TCF_CTRL_QSRC 1
`define TCF_CMD_CORR 0
`define TCF_SET_LDSEC 24
`define TCF_SET_LDMIN 25
`define TCF_SET_LDHR 26
`define TCF_ST_FAULTEN 12
`define TCF_ST_PLUS 13
`define TCF_ST_MINUS 14
`define TCF_ST_BLINK 15

// ==========================================================
// Decade limits and answers
`define TCF_UNITS_MAX 4'h9
`define TCF_TENS_MAX 4'h5
`define TCF_HOUR_TENS_LAST 4'h2
`define TCF_HOUR_UNITS_LAST 4'h3
`define TCF_RANGE_IDLE 2'h3
`define TCF_RESP_OKAY 2'h0
`define TCF_RESP_SLVERR 2'h2

`endif

/* File: inc/tcf_pkg.sv */
// Types shared by the time counter and control block
package tcf_pkg;

    // Function selector, one-hot
    typedef enum logic [3:0] {
        FN_TIME = 4'h1,
        FN_INTERVAL = 4'h2,
        FN_DEVIATION = 4'h4,
        FN_OFF = 4'h8
    } tcf_func_t;

    // Complete register state of the block
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic setMode;
        logic querySel;
        logic [25:0] tickCnt;
        logic [22:0] blinkCnt;
        logic blinkPhase;
        logic [3:0] secU;
        logic [3:0] secT;
        logic [3:0] minU;
        logic [3:0] minT;
        logic [3:0] hrU;
        logic [3:0] hrT;
        tcf_func_t func;
        logic [1:0] range;
        logic [3:0] rangeSel;
        logic [3:0] digitCode;
        logic digitBlank;
        logic [11:0] corrShortCnt;
        logic [14:0] corrLongCnt;
        logic divRst10;
        logic divRst1;
        logic queryOut;
        logic devPrev;
        logic mainDivZero;
        logic mixClear;
        logic mixPreset9;
        logic lampTime;
        logic lampInterval;
        logic lampDeviation;
        logic lampPlus;
        logic lampMinus;
        logic lampRed;
        logic lampGreen;
        logic faultDecEn;
        logic [3:0] faultCode;
    } tcf_state_t;

endpackage

/* File: verif/tb.sv */
// Self-checking bench of the time counter and control block
`timescale 1ns/1ps
`default_nettype none
`include "tcf_defines.svh"
module tb;
    import tcf_pkg::*;
    logic sys_clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 4'hf, digitCode, rangeSel, faultCode;
    logic [2:0] wantSel = 0, scanSel;
    logic [1:0] bresp, rresp, rs;
    logic pressF = 0, pressS = 0, funcBtnPulse, startBtnPulse, extScale = 0, auxScale = 0;
    logic devPulseN = 1, cmpPlus = 0, cmpMinus = 0, harmLock = 1;
    logic [8:0] faultFlags = 0;
    logic awready, wready, bvalid, arready, rvalid, digitBlank, lampTime, lampInterval;
    logic lampDeviation, queryOut, divRst10, divRst1, mainDivZero, mixClear, mixPreset9;
    logic lampPlus, lampMinus, lampRed, lampGreen, faultDecEn;
    int error_cnt = 0, check_count = 0, n1 = 0, n10 = 0, nz = 0;
    tcf_time_control #(.SEC_CYCLES(20), .BLINK_HALF_CYCLES(4), .CORR_LONG_CYCLES(40))
        tcf_time_control_i (.*);
    tcf_panel_model tcf_panel_model_i (.*);
    // ==========================================================
    // Clock, pulse counters and shared tasks
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        n1 += divRst1;
        n10 += divRst10;
        nz += mainDivZero & mixClear & mixPreset9;
    end
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        int t = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            t++;
        end while (!bvalid && t < 200);
        rs = bresp;
        bready <= 0;
        chk("write done", 1, t < 200);
    endtask
    task automatic rdr(logic [7:0] a);
        int t = 0;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 0;
            t++;
        end while (!rvalid && t < 200);
        rd = rdata;
        rs = rresp;
        rready <= 0;
        chk("read done", 1, t < 200);
    endtask
    task automatic press(bit f);
        if (f) pressF <= 1;
        else pressS <= 1;
        tick(1);
        pressF <= 0;
        pressS <= 0;
        tick(3);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_select;
        logic [3:0] e;
        for (int i = 1; i <= 4; i++) begin
            press(1);
            e = 4'h1 << (i % 4);
            rdr(`TCF_OFS_STATUS);
            chk("func", e, rd[3:0]);
            chk("lamps", e[2:0], {lampDeviation, lampInterval, lampTime});
            press(0);
            chk("range", e, rangeSel);
        end
        $display("select test ended");
    endtask
    task automatic t_time;
        wr(`TCF_OFS_SETTIME, 32'h0721_4700);
        wr(`TCF_OFS_SETTIME, 32'h0200_1300);
        for (int i = 2; i < 7; i++) begin
            wantSel <= 3'(i);
            tick(3);
            chk("digit", i > 5 ? 1 : 0, digitBlank);
            if (i < 6) chk("code", 32'h2113 >> (4 * (i - 2)) & 32'hf, digitCode);
        end
        wr(`TCF_OFS_SETTIME, 32'h0723_5958);
        tick(8);
        rdr(`TCF_OFS_TIME);
        chk("time", 32'h23_5958, rd);
        tick(18);
        rdr(`TCF_OFS_TIME);
        chk("time", 32'h23_5959, rd);
        tick(18);
        rdr(`TCF_OFS_TIME);
        chk("time", 32'h0, rd);
        $display("time test ended");
    endtask
    task automatic t_pulses;
        wr(`TCF_OFS_CTRL, 32'h2);
        extScale <= 1;
        tick(3);
        chk("query", 1, queryOut);
        wr(`TCF_OFS_CTRL, 32'h0);
        tick(2);
        chk("query", 0, queryOut);
        n1 = 0;
        n10 = 0;
        wr(`TCF_OFS_CMD, 32'h1);
        chk("cmd bresp", 0, rs);
        tick(2600);
        chk("long reset", 40, n1);
        chk("short reset", 2500, n10);
        for (int f = 0; f < 2; f++) begin
            nz = 0;
            devPulseN <= 0;
            tick(4);
            devPulseN <= 1;
            tick(3);
            chk("zero pulse", f, nz);
            press(1);
            press(1);
        end
        $display("pulse test ended");
    endtask
    task automatic t_panel;
        int nb = 0;
        logic pr;
        wr(`TCF_OFS_CTRL, 32'h1);
        for (int i = 0; i < 80; i++) begin
            wantSel <= i < 40 ? 3'h0 : 3'h2;
            tick(1);
            if (i > 2 && i < 40) nb += digitBlank;
            if (i > 42) chk("unset digit", 0, digitBlank);
        end
        chk("flash", 1, nb > 10 && nb < 28);
        wr(`TCF_OFS_CTRL, 32'h0);
        cmpPlus <= 1;
        harmLock <= 0;
        faultFlags <= 9'h048;
        wantSel <= 3'h0;
        tick(3);
        chk("plus", 2'b01, {lampMinus, lampPlus});
        chk("decoder", 2'b10, {faultDecEn, lampGreen});
        chk("fault", 4, faultCode);
        chk("shown", 4, digitCode);
        nb = 0;
        pr = lampRed;
        for (int i = 0; i < 20; i++) begin
            tick(1);
            nb += (lampRed !== pr);
            pr = lampRed;
        end
        chk("red flash", 1, nb > 2);
        faultFlags <= 9'h040;
        tick(3);
        chk("unused code", 0, faultCode);
        rdr(8'h14);
        chk("unmapped", 2, rs);
        harmLock <= 1;
        $display("panel test ended");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        tick(20);
        rstn <= 1;
        tick(3);
        t_select();
        t_time();
        t_pulses();
        t_panel();
        conclude();
    end
    // Hang guard, far beyond the few thousand cycles the run needs
    initial begin
        tick(20000);
        error_cnt++;
        conclude();
    end
endmodule // tb
`default_nettype wire

/* File: verif/tcf_panel_model.sv */
// Front panel and display scan model facing the time counter block
`timescale 1ns/1ps
`default_nettype none
module tcf_panel_model (
    // Clock
    input wire logic sys_clk,
    // Requests from the bench
    input wire logic pressF,
    input wire logic pressS,
    input wire logic [2:0] wantSel,
    // Panel lines toward the block
    output logic funcBtnPulse,
    output logic startBtnPulse,
    output logic [2:0] scanSel
);
    // Buttons give one clean pulse per press, scan steps on request
    always_ff @(posedge sys_clk) begin
        funcBtnPulse <= pressF;
        startBtnPulse <= pressS;
        scanSel <= wantSel;
    end
endmodule // tcf_panel_model
`default_nettype wire
